// ==== nvcfg_bank.v ====
// nonvolatile default-configuration bank: AXI4-Lite slave, five byte registers and decoded settings
// assumes the strap pins are asynchronous and static; decoded outputs lag a write by one cycle
//
// The AXI4-Lite register port was decided locally.
`include "nvcfg_defines.vh"

module nvcfg_bank #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address channel
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address channel
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // address straps
    input wire address_strap_bit2,
    input wire address_strap_bit1,
    input wire address_strap_bit0,
    // decoded settings
    output reg [3:0] device_address,
    output reg [14:0] pwm_frequency_hz,
    output reg failure_all_off,
    output reg [9:0] reference_ratio,
    output reg [13:0] link_timeout_us,
    output reg [4:0] low_supply_threshold_v,
    output reg [5:0] ondemand_diag_current_num,
    output reg ondemand_diag_use_channel,
    output reg [12:0] ondemand_diag_pulse_us,
    output reg watchdog_enable,
    output reg watchdog_immediate,
    output reg [18:0] watchdog_period_us,
    output reg [15:0] init_timer_us
);
    localparam NREG = 5;
    localparam [10*NREG-1:0] IDX = {`NVCFG_IDX_WDT, `NVCFG_IDX_DIAG, `NVCFG_IDX_TMO,
        `NVCFG_IDX_PWM, `NVCFG_IDX_ADDR};
    localparam [8*NREG-1:0] RSTV = {`NVCFG_RST_WDT, `NVCFG_RST_DIAG, `NVCFG_RST_TMO,
        `NVCFG_RST_PWM, `NVCFG_RST_ADDR};
    localparam [8*NREG-1:0] MSKV = {`NVCFG_MASK_WDT, `NVCFG_MASK_DIAG, `NVCFG_MASK_TMO,
        `NVCFG_MASK_PWM, `NVCFG_MASK_ADDR};

    ////////////////////////////////////////////////////////////////////////////
    // decode tables

    function [14:0] pwm_hz;
        input [3:0] code;
        begin
            case (code)
                4'h0: pwm_hz = 15'd200;
                4'h1: pwm_hz = 15'd250;
                4'h2: pwm_hz = 15'd300;
                4'h3: pwm_hz = 15'd350;
                4'h4: pwm_hz = 15'd400;
                4'h5: pwm_hz = 15'd500;
                4'h6: pwm_hz = 15'd600;
                4'h7: pwm_hz = 15'd800;
                4'h8: pwm_hz = 15'd1000;
                4'h9: pwm_hz = 15'd1200;
                4'hA: pwm_hz = 15'd2000;
                4'hB: pwm_hz = 15'd4000;
                4'hC: pwm_hz = 15'd5900;
                4'hD: pwm_hz = 15'd7800;
                4'hE: pwm_hz = 15'd9600;
                default: pwm_hz = 15'd20800;
            endcase
        end
    endfunction

    function [13:0] timeout_us;
        input [2:0] code;
        begin
            case (code)
                3'h0: timeout_us = 14'd1000;
                3'h1: timeout_us = 14'd125;
                3'h2: timeout_us = 14'd250;
                3'h3: timeout_us = 14'd500;
                3'h4: timeout_us = 14'd1250;
                3'h5: timeout_us = 14'd2500;
                3'h6: timeout_us = 14'd5000;
                default: timeout_us = 14'd10000;
            endcase
        end
    endfunction

    function [12:0] pulse_us;
        input [3:0] code;
        begin
            case (code)
                4'h0: pulse_us = 13'd100;
                4'h1: pulse_us = 13'd20;
                4'h2: pulse_us = 13'd30;
                4'h3: pulse_us = 13'd50;
                4'h4: pulse_us = 13'd80;
                4'h5: pulse_us = 13'd150;
                4'h6: pulse_us = 13'd200;
                4'h7: pulse_us = 13'd300;
                4'h8: pulse_us = 13'd500;
                4'h9: pulse_us = 13'd800;
                4'hA: pulse_us = 13'd1000;
                4'hB: pulse_us = 13'd1200;
                4'hC: pulse_us = 13'd1500;
                4'hD: pulse_us = 13'd2000;
                4'hE: pulse_us = 13'd3000;
                default: pulse_us = 13'd5000;
            endcase
        end
    endfunction

    // codes 0 and 12..15 carry no period
    function [18:0] wdt_us;
        input [3:0] code;
        begin
            case (code)
                4'h1: wdt_us = 19'd200;
                4'h2: wdt_us = 19'd500;
                4'h3: wdt_us = 19'd1000;
                4'h4: wdt_us = 19'd2000;
                4'h5: wdt_us = 19'd5000;
                4'h6: wdt_us = 19'd10000;
                4'h7: wdt_us = 19'd20000;
                4'h8: wdt_us = 19'd50000;
                4'h9: wdt_us = 19'd100000;
                4'hA: wdt_us = 19'd200000;
                4'hB: wdt_us = 19'd500000;
                default: wdt_us = 19'd0;
            endcase
        end
    endfunction

    function [15:0] init_us;
        input [3:0] code;
        begin
            case (code)
                4'h0: init_us = 16'd0;
                4'h1: init_us = 16'd50000;
                4'h2: init_us = 16'd20000;
                4'h3: init_us = 16'd10000;
                4'h4: init_us = 16'd5000;
                4'h5: init_us = 16'd2000;
                4'h6: init_us = 16'd1000;
                4'h7: init_us = 16'd500;
                4'h8: init_us = 16'd200;
                4'h9: init_us = 16'd100;
                default: init_us = 16'd50;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write path: address and data may arrive in either order

    reg aw_held;
    reg w_held;
    reg [ADDR_W-1:0] aw_addr;
    reg [7:0] w_byte;
    reg w_lane0;
    wire do_write;
    wire [9:0] wr_idx;
    reg wr_hit;
    wire [NREG-1:0] wr_sel;
    wire [8*NREG-1:0] reg_q;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = aw_addr[11:2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `NVCFG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `NVCFG_RESP_OKAY : `NVCFG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register store

    genvar i;
    generate
        for (i = 0; i < NREG; i = i + 1) begin : g_reg
            // a cleared lane-0 strobe leaves the byte untouched
            assign wr_sel[i] = do_write && w_lane0 && (wr_idx == IDX[10*i +: 10]);
            nvcfg_reg8 #(
                .RESET(RSTV[8*i +: 8]),
                .MASK(MSKV[8*i +: 8])
            ) u_reg (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_en(wr_sel[i]),
                .wr_data(w_byte),
                .q(reg_q[8*i +: 8])
            );
        end
    endgenerate

    integer k;
    always @* begin
        wr_hit = 1'b0;
        for (k = 0; k < NREG; k = k + 1) begin
            if (wr_idx == IDX[10*k +: 10]) begin
                wr_hit = 1'b1;
            end
        end
    end

    wire [7:0] r_addr = reg_q[7:0];
    wire [7:0] r_pwm = reg_q[15:8];
    wire [7:0] r_tmo = reg_q[23:16];
    wire [7:0] r_diag = reg_q[31:24];
    wire [7:0] r_wdt = reg_q[39:32];

    ////////////////////////////////////////////////////////////////////////////
    // read path: one outstanding read, data registered with the answer

    reg [7:0] next_rbyte;
    reg next_rhit;
    integer m;
    wire [9:0] rd_idx = s_axi_araddr[11:2];

    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        next_rbyte = 8'h00;
        next_rhit = 1'b0;
        for (m = 0; m < NREG; m = m + 1) begin
            if (rd_idx == IDX[10*m +: 10]) begin
                next_rbyte = reg_q[8*m +: 8];
                next_rhit = 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `NVCFG_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, next_rbyte};
            s_axi_rresp <= next_rhit ? `NVCFG_RESP_OKAY : `NVCFG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap pins

    wire [2:0] strap_sync;

    nvcfg_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin({address_strap_bit2, address_strap_bit1, address_strap_bit0}),
        .q(strap_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decoded settings, registered so outputs never glitch on a write

    wire [3:0] pwm_frequency_select = r_pwm[`NVCFG_HI_NIB];
    wire address_source_select = r_pwm[`NVCFG_ADDR_SRC_BIT];
    wire failure_policy_select = r_pwm[`NVCFG_FAIL_BIT];
    wire [1:0] reference_ratio_select = r_pwm[`NVCFG_REF_FIELD];
    wire [2:0] link_timeout_select = r_tmo[`NVCFG_TMO_FIELD];
    wire [3:0] low_supply_threshold = r_tmo[`NVCFG_LO_NIB];
    wire [3:0] ondemand_diag_current = r_diag[`NVCFG_HI_NIB];
    wire [3:0] ondemand_diag_pulse_width = r_diag[`NVCFG_LO_NIB];
    wire [3:0] watchdog_period_select = r_wdt[`NVCFG_HI_NIB];
    wire [3:0] init_timer_select = r_wdt[`NVCFG_LO_NIB];
    wire [3:0] stored_device_address = r_addr[`NVCFG_LO_NIB];

    always @(posedge aclk) begin
        if (!aresetn) begin
            device_address <= 4'h0;
            pwm_frequency_hz <= 15'd2000;
            failure_all_off <= 1'b1;
            reference_ratio <= 10'd512;
            link_timeout_us <= 14'd1000;
            low_supply_threshold_v <= 5'd8;
            ondemand_diag_current_num <= 6'd1;
            ondemand_diag_use_channel <= 1'b0;
            ondemand_diag_pulse_us <= 13'd100;
            watchdog_enable <= 1'b0;
            watchdog_immediate <= 1'b0;
            watchdog_period_us <= 19'd0;
            init_timer_us <= 16'd0;
        end else begin
            // stored field or straps, see RULE2 and RULE11
            device_address <= address_source_select ? stored_device_address : {1'b0, strap_sync};
            pwm_frequency_hz <= pwm_hz(pwm_frequency_select); // see RULE1
            failure_all_off <= failure_policy_select; // see RULE3
            reference_ratio <= 10'd64 << reference_ratio_select; // see RULE4
            link_timeout_us <= timeout_us(link_timeout_select); // see RULE5
            low_supply_threshold_v <= `NVCFG_SUPPLY_BASE_V + {1'b0, low_supply_threshold}; // see RULE6
            // numerator over 64 of full range, see RULE7
            ondemand_diag_current_num <= {ondemand_diag_current, 2'b01};
            ondemand_diag_use_channel <= (ondemand_diag_current == `NVCFG_DIAG_OWN_CODE);
            ondemand_diag_pulse_us <= pulse_us(ondemand_diag_pulse_width); // see RULE8
            // code 0 disables, high codes skip straight to fail-safe, see RULE9
            watchdog_enable <= (watchdog_period_select != 4'h0) &&
                (watchdog_period_select < `NVCFG_WDT_IMMED_CODE);
            watchdog_immediate <= (watchdog_period_select >= `NVCFG_WDT_IMMED_CODE);
            watchdog_period_us <= wdt_us(watchdog_period_select);
            init_timer_us <= init_us(init_timer_select); // see RULE10
        end
    end
endmodule

// ==== nvcfg_bank_bench.sv ====
// self-checking bench for the default-configuration register bank
// assumes the host model drives the bus; straps come from here
module nvcfg_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic address_strap_bit2 = 1'b1, address_strap_bit1 = 1'b0, address_strap_bit0 = 1'b1;
    wire [11:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [2:0] s_axi_awprot, s_axi_arprot;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire [3:0] device_address;
    wire [14:0] pwm_frequency_hz;
    wire [9:0] reference_ratio;
    wire [13:0] link_timeout_us;
    wire [4:0] low_supply_threshold_v;
    wire [5:0] ondemand_diag_current_num;
    wire [12:0] ondemand_diag_pulse_us;
    wire [18:0] watchdog_period_us;
    wire [15:0] init_timer_us;
    wire failure_all_off, ondemand_diag_use_channel, watchdog_enable, watchdog_immediate;
    int mismatches = 0;
    int samples_checked = 0;
    int pwm_t[16] = '{200, 250, 300, 350, 400, 500, 600, 800, 1000, 1200, 2000, 4000, 5900, 7800, 9600, 20800};
    int tmo_t[8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 10000};
    int pw_t[16] = '{100, 20, 30, 50, 80, 150, 200, 300, 500, 800, 1000, 1200, 1500, 2000, 3000, 5000};
    int wd_t[16] = '{0, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000, 500000, 0, 0, 0, 0};
    int it_t[16] = '{0, 50000, 20000, 10000, 5000, 2000, 1000, 500, 200, 100, 50, 50, 50, 50, 50, 50};

    nvcfg_bank dut (.*);
    nvcfg_host host (.*);

    initial begin
        forever #20 aclk = ~aclk;
    end

    ////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task wrb(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [31:0] q;
        logic [1:0] r;
        host.wr(a, d, r);
        chk("bresp", 32'h00000000, {30'h0, r});
        host.rd(a, q, r);
        chk("readback", {24'h000000, e}, q);
    endtask

    task finish_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////
    task t_reset;
        logic [31:0] q;
        logic [1:0] r;
        logic [7:0] rv[5];
        rv = '{8'h00, 8'hA7, 8'h03, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            host.rd(12'h318 + 12'(4 * i), q, r);
            chk("reset value", {24'h000000, rv[i]}, q);
        end
        chk("pwm", 32'd2000, 32'(pwm_frequency_hz));
        chk("ratio", 32'd512, 32'(reference_ratio));
        chk("policy", 32'd1, 32'(failure_all_off));
        chk("supply", 32'd8, 32'(low_supply_threshold_v));
        chk("strap addr", 32'd5, 32'(device_address));
    endtask

    task t_first;
        logic [7:0] v;
        for (int c = 0; c < 16; c++) begin
            v = {4'(c), 1'b0, c[0], c[1:0]};
            wrb(12'h31C, v, v);
            chk("pwm", 32'(pwm_t[c]), 32'(pwm_frequency_hz));
            chk("ratio", 32'd64 << c[1:0], 32'(reference_ratio));
            chk("policy", 32'(c[0]), 32'(failure_all_off));
        end
    endtask

    task t_second;
        for (int c = 0; c < 8; c++) begin
            wrb(12'h320, {1'b1, 3'(c), 4'(c * 2)}, {1'b0, 3'(c), 4'(c * 2)});
            chk("timeout", 32'(tmo_t[c]), 32'(link_timeout_us));
            chk("supply", 32'(c * 2 + 5), 32'(low_supply_threshold_v));
        end
    endtask

    task t_diag_wdt;
        for (int c = 0; c < 16; c++) begin
            wrb(12'h324, {4'(c), 4'(c)}, {4'(c), 4'(c)});
            chk("pulse", 32'(pw_t[c]), 32'(ondemand_diag_pulse_us));
            chk("own current", 32'(c == 15), 32'(ondemand_diag_use_channel));
            if (c < 15)
                chk("current", 32'(c * 4 + 1), 32'(ondemand_diag_current_num));
            wrb(12'h328, {4'(c), 4'(c)}, {4'(c), 4'(c)});
            chk("wdt period", 32'(wd_t[c]), 32'(watchdog_period_us));
            chk("wdt on", 32'(c >= 1 && c <= 11), 32'(watchdog_enable));
            chk("wdt now", 32'(c >= 12), 32'(watchdog_immediate));
            chk("init", 32'(it_t[c]), 32'(init_timer_us));
        end
    endtask

    task t_addr;
        logic [31:0] q;
        logic [1:0] r;
        wrb(12'h318, 8'h0A, 8'h0A);
        wrb(12'h31C, 8'hAF, 8'hAF);
        chk("stored addr", 32'd10, 32'(device_address));
        address_strap_bit2 <= 1'b0;
        address_strap_bit1 <= 1'b1;
        address_strap_bit0 <= 1'b0;
        wrb(12'h31C, 8'hA7, 8'hA7);
        repeat (3) @(posedge aclk);
        chk("strap addr", 32'd2, 32'(device_address));
        host.wr(12'h32C, 8'h55, r);
        chk("bad bresp", 32'd2, 32'(r));
        host.rd(12'h32C, q, r);
        chk("bad rresp", 32'd2, 32'(r));
        chk("bad rdata", 32'h00000000, q);
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset();
        t_first();
        t_second();
        t_diag_wdt();
        t_addr();
        finish_test();
    end

    // whole run needs a few hundred cycles
    initial begin
        #800000;
        mismatches++;
        finish_test();
    end
endmodule

// ==== nvcfg_bank_props.sv ====
// concurrent checks on the register bank ports
// assumes a master with one write and one read at most in flight
module nvcfg_bank_props #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write side
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // read side
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // decoded settings
    input wire failure_all_off,
    input wire [9:0] reference_ratio,
    input wire [4:0] low_supply_threshold_v,
    input wire [5:0] ondemand_diag_current_num,
    input wire ondemand_diag_use_channel,
    input wire watchdog_enable,
    input wire watchdog_immediate,
    input wire [18:0] watchdog_period_us
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [11:0] rd_addr;

    // read data is tied back to the decode through the address taken
    always @(posedge aclk) begin
        if (!aresetn)
            rd_addr <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr <= s_axi_araddr[11:0];
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response withdrawn early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data withdrawn early");
    chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |=> ##[0:1] s_axi_bvalid) else $error("write response late");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_ratio_read: assert property (s_axi_rvalid && rd_addr == 12'h31C |->
        reference_ratio == (10'h040 << s_axi_rdata[1:0])) else $error("ratio decode wrong");
    chk_policy_read: assert property (s_axi_rvalid && rd_addr == 12'h31C |->
        failure_all_off == s_axi_rdata[2]) else $error("failure policy decode wrong");
    chk_top_zero: assert property (s_axi_rvalid && rd_addr == 12'h320 |->
        s_axi_rdata[31:7] == 25'h0000000) else $error("reserved bit reads nonzero");
    chk_supply_read: assert property (s_axi_rvalid && rd_addr == 12'h320 |->
        low_supply_threshold_v == {1'b0, s_axi_rdata[3:0]} + 5'h05) else $error("threshold decode wrong");
    chk_wdt_excl: assert property (watchdog_immediate |->
        !watchdog_enable && watchdog_period_us == 19'h00000) else $error("watchdog modes overlap");
    chk_diag_num: assert property (s_axi_rvalid && rd_addr == 12'h324 |->
        ondemand_diag_current_num == {s_axi_rdata[7:4], 2'h1} &&
        ondemand_diag_use_channel == (s_axi_rdata[7:4] == 4'hF)) else $error("diag current decode wrong");
endmodule

bind nvcfg_bank nvcfg_bank_props #(.ADDR_W(ADDR_W)) props (.*);

// ==== nvcfg_defines.vh ====
// constants for the nonvolatile default-configuration register bank
// assumes an AXI4-Lite slave on a 25 MHz clock; register index times four is the byte address
//
// Overview of operation
// RULE1: bits 7-4 of the first register pick one of sixteen PWM frequencies, 200 Hz at code 0 to 20.8 kHz at code 15, reset code 10.
// RULE2: bit 3 of the first register takes the device address from the three strap pins when clear, from the stored field when set.
// RULE3: bit 2 of the first register, reset one, turns all channels off on any channel failure when set, keeps others on when clear.
// RULE4: bits 1-0 of the first register pick a reference current ratio of 64, 128, 256 or 512, reset code 3.
// RULE5: bits 6-4 of the second register pick the link timeout, 1 ms at code 0, then 125 us up to 10 ms for codes 1 to 7.
// RULE6: bits 3-0 of the second register set the low-supply threshold from 5 V to 20 V in one-volt steps, reset code 3.
// RULE7: bits 7-4 of the third register give diagnostic current as full range times (code*4+1)/64, code 15 uses the channel current.
// RULE8: bits 3-0 of the third register pick the diagnostic pulse width, 100 us at code 0, 20 us to 5 ms for codes 1 to 15.
// RULE9: bits 7-4 of the fourth register set the watchdog, code 0 off, codes 1 to 11 a period, codes 12 to 15 immediate fail-safe.
// RULE10: bits 3-0 of the fourth register set the init timer, 0 ms at code 0, 50 ms down to 100 us, codes 10 to 15 give 50 us.
// RULE11: with stored addressing, the device address is bits 3-0 of the neighbouring address register.
// RULE12: the top bit of the second register always reads zero and writes to it change nothing.
`ifndef NVCFG_DEFINES_VH
`define NVCFG_DEFINES_VH

// register indexes, byte address is index * 4
`define NVCFG_IDX_ADDR 10'h0C6
`define NVCFG_IDX_PWM 10'h0C7
`define NVCFG_IDX_TMO 10'h0C8
`define NVCFG_IDX_DIAG 10'h0C9
`define NVCFG_IDX_WDT 10'h0CA

// reset values
`define NVCFG_RST_ADDR 8'h00
`define NVCFG_RST_PWM 8'hA7
`define NVCFG_RST_TMO 8'h03
`define NVCFG_RST_DIAG 8'h00
`define NVCFG_RST_WDT 8'h00

// writable bits
`define NVCFG_MASK_ADDR 8'h0F
`define NVCFG_MASK_PWM 8'hFF
`define NVCFG_MASK_TMO 8'h7F
`define NVCFG_MASK_DIAG 8'hFF
`define NVCFG_MASK_WDT 8'hFF

// field positions
`define NVCFG_HI_NIB 7:4
`define NVCFG_LO_NIB 3:0
`define NVCFG_TMO_FIELD 6:4
`define NVCFG_ADDR_SRC_BIT 3
`define NVCFG_FAIL_BIT 2
`define NVCFG_REF_FIELD 1:0

// answers
`define NVCFG_RESP_OKAY 2'h0
`define NVCFG_RESP_SLVERR 2'h2

// decode constants
`define NVCFG_SUPPLY_BASE_V 5'h05
`define NVCFG_DIAG_OWN_CODE 4'hF
`define NVCFG_WDT_IMMED_CODE 4'hC

`endif

// ==== nvcfg_host.sv ====
// host-side AXI4-Lite master standing in for the control software
// assumes tasks are entered just after a rising edge of aclk
module nvcfg_host (
    // clock
    input wire aclk,
    // write channels
    output logic [11:0] s_axi_awaddr = 12'h000,
    output logic [2:0] s_axi_awprot = 3'h0,
    output logic s_axi_awvalid = 1'b0,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h00000000,
    output logic [3:0] s_axi_wstrb = 4'h1,
    output logic s_axi_wvalid = 1'b0,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    // read channels
    output logic [11:0] s_axi_araddr = 12'h000,
    output logic [2:0] s_axi_arprot = 3'h0,
    output logic s_axi_arvalid = 1'b0,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            // released lines do not keep their old value
            if (s_axi_awready && !ta) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wready && !tw) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~{24'h000000, d};
            end
        end while (!(ta && tw));
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// ==== nvcfg_reg8.v ====
// one byte-wide configuration register with a writable-bit mask
// assumes the write enable is a one-cycle pulse from the bus slave
module nvcfg_reg8 #(
    parameter [7:0] RESET = 8'h00,
    parameter [7:0] MASK = 8'hFF
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write port
    input wire wr_en,
    input wire [7:0] wr_data,
    // content
    output reg [7:0] q
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            q <= RESET;
        end else if (wr_en) begin
            // masked bits stay zero for good, see RULE12
            q <= wr_data & MASK;
        end
    end
endmodule

// ==== nvcfg_sync.v ====
// two-flop synchroniser for a bundle of slow static pins
// assumes the pins are quasi-static, so bits may resolve one cycle apart
module nvcfg_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pins and result
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else begin
            meta <= pin;
            q <= meta;
        end
    end
endmodule
